//--- hdl/eps_pkg.sv
// Constants, types and helpers for the positive-node switch control block
// Overview of operation
// - Bit 13 closes the output-to-positive short switch and bit 14 closes the second load-path switch.
// - Bit 10 closes the counter electrode switch when set, opens it when clear, and resets open.
// - Bit 8 closes the switch to the third front-end pin when 1 and opens it when 0.
// - Bit 7 closes the switch to the drive electrode pin when 1 and opens it when 0.
// - Bit 6 closes the switch to the sense electrode pin when 1 and opens it when 0.
// - Bit 5 closes the switch to the second front-end pin when 1 and opens it when 0.
// - Bit 4 closes the switch to the reference electrode pin when 1 and opens it when 0.
// - Bit 3 closes the switch to analog input three when 1 and opens it when 0.
// - Bit 2 closes the switch to analog input two when 1 and opens it when 0.
package eps_pkg;

    // Register map
    localparam logic [31:0] EPS_MATRIX_OFFSET = 32'h0000_2158;
    localparam logic [31:0] EPS_MATRIX_RESET = 32'h0000_0000;
    // Bits that store a write; everything else reads zero
    localparam logic [31:0] EPS_MATRIX_WMASK = 32'h0000_7FFC;

    // Field positions
    localparam int EPS_BIT_LOAD_B = 14;
    localparam int EPS_BIT_SHORT = 13;
    localparam int EPS_BIT_COUNTER = 10;
    localparam int EPS_BIT_FE_THREE = 8;
    localparam int EPS_BIT_DRIVE = 7;
    localparam int EPS_BIT_SENSE = 6;
    localparam int EPS_BIT_FE_TWO = 5;
    localparam int EPS_BIT_REFERENCE = 4;
    localparam int EPS_BIT_AIN_THREE = 3;
    localparam int EPS_BIT_AIN_TWO = 2;

    // Bus responses
    localparam logic [1:0] EPS_RESP_OKAY = 2'h0;
    localparam logic [1:0] EPS_RESP_SLVERR = 2'h2;

    // Switch control lines, high means closed
    typedef struct packed {
        logic load_path_switch_b;
        logic output_to_positive_short_switch;
        logic counter_electrode_switch;
        logic front_end_three_switch;
        logic drive_electrode_switch;
        logic sense_electrode_switch;
        logic front_end_two_switch;
        logic reference_electrode_switch;
        logic analog_input_three_switch;
        logic analog_input_two_switch;
    } eps_switch_s;

    typedef enum logic [1:0] {
        EPS_WS_IDLE,
        EPS_WS_HAVE_ADDR,
        EPS_WS_HAVE_DATA,
        EPS_WS_RESP
    } eps_wr_state_e;

    typedef enum logic {
        EPS_RS_IDLE,
        EPS_RS_DATA
    } eps_rd_state_e;

    // Word-aligned address compare against the register's byte address
    function automatic logic eps_addr_hit(input logic [31:0] addr);
        eps_addr_hit = (addr[31:2] == EPS_MATRIX_OFFSET[31:2]);
    endfunction

endpackage

//--- hdl/eps_reg_word.sv
// Storage flop for the switch matrix word with byte-strobe merge
`timescale 1ns/10ps
module eps_reg_word
(
    // Clock and control
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Write request
    input wire logic wr_en,
    input wire logic [31:0] wr_data,
    input wire logic [3:0] wr_strb,
    // Stored word
    output logic [31:0] q
);
    import eps_pkg::*;

    logic [31:0] word_r;
    logic [31:0] word_nxt;
    logic [31:0] lane_mask;

    // Merge enabled lanes into the writable bits only
    always_comb
    begin
        lane_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
        word_nxt = word_r;
        if (wr_en)
        begin
            word_nxt = (word_r & ~(lane_mask & EPS_MATRIX_WMASK))
                | (wr_data & lane_mask & EPS_MATRIX_WMASK);
        end
    end

    // reset low, update on write edge
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            word_r <= EPS_MATRIX_RESET;
        else if (ce)
            word_r <= word_nxt;
    end

    assign q = word_r;
endmodule

//--- hdl/eps_switch_map.sv
// Maps stored word bits onto the static switch control lines
`timescale 1ns/10ps
module eps_switch_map
(
    // Stored register word
    input wire logic [31:0] word,
    // Switch control lines
    output eps_pkg::eps_switch_s sw
);
    import eps_pkg::*;

    // Pure wiring from flops, so lines change at the write edge itself
    always_comb
    begin
        sw.load_path_switch_b = word[EPS_BIT_LOAD_B];
        sw.output_to_positive_short_switch = word[EPS_BIT_SHORT];
        sw.counter_electrode_switch = word[EPS_BIT_COUNTER];
        sw.front_end_three_switch = word[EPS_BIT_FE_THREE];
        sw.drive_electrode_switch = word[EPS_BIT_DRIVE];
        sw.sense_electrode_switch = word[EPS_BIT_SENSE];
        sw.front_end_two_switch = word[EPS_BIT_FE_TWO];
        sw.reference_electrode_switch = word[EPS_BIT_REFERENCE];
        sw.analog_input_three_switch = word[EPS_BIT_AIN_THREE];
        sw.analog_input_two_switch = word[EPS_BIT_AIN_TWO];
    end
endmodule

//--- hdl/eps_switch_ctrl.sv
// AXI4-Lite slave holding the positive-node switch matrix register
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
module eps_switch_ctrl
#(
    parameter int ADDR_W = 16
)
(
    // Clock, reset and clock enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Write address channel
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // Write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read address channel
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // Read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Switch control lines to the analog matrix
    output eps_pkg::eps_switch_s switches
);
    import eps_pkg::*;

    // The register's byte address must fit the bus address
    generate
        if (ADDR_W < 14 || ADDR_W > 32)
        begin : g_bad_addr_w
            $error("eps_switch_ctrl: ADDR_W must lie between 14 and 32");
        end
    endgenerate

    // Write path state
    eps_wr_state_e ws_r;
    eps_wr_state_e ws_nxt;
    logic [ADDR_W-1:0] awaddr_r;
    logic [ADDR_W-1:0] awaddr_nxt;
    logic [31:0] wdata_r;
    logic [31:0] wdata_nxt;
    logic [3:0] wstrb_r;
    logic [3:0] wstrb_nxt;
    logic [1:0] bresp_r;
    logic [1:0] bresp_nxt;

    // Read path state
    eps_rd_state_e rs_r;
    eps_rd_state_e rs_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0] rresp_r;
    logic [1:0] rresp_nxt;

    // Write commit signals
    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_hit;
    logic reg_wr_en;

    // Read handshake
    logic ar_take;

    // Stored word
    logic [31:0] matrix_q;

    // Protection bits carry no meaning for this register
    logic unused_prot;
    assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

    // Ready outputs decode straight from state; a frozen clock enable stalls them
    always_comb
    begin
        s_axi_awready = ce && (ws_r == EPS_WS_IDLE || ws_r == EPS_WS_HAVE_DATA);
        s_axi_wready = ce && (ws_r == EPS_WS_IDLE || ws_r == EPS_WS_HAVE_ADDR);
        s_axi_arready = ce && (rs_r == EPS_RS_IDLE);
    end

    // Handshakes on this edge
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign ar_take = s_axi_arvalid && s_axi_arready;

    // Pick the address and data for the write that completes now
    always_comb
    begin
        wr_fire = 1'b0;
        wr_addr = awaddr_r;
        wr_data = wdata_r;
        wr_strb = wstrb_r;
        case (ws_r)
            EPS_WS_IDLE:
            begin
                wr_fire = aw_take && w_take;
                wr_addr = s_axi_awaddr;
                wr_data = s_axi_wdata;
                wr_strb = s_axi_wstrb;
            end
            EPS_WS_HAVE_ADDR:
            begin
                wr_fire = w_take;
                wr_data = s_axi_wdata;
                wr_strb = s_axi_wstrb;
            end
            EPS_WS_HAVE_DATA:
            begin
                wr_fire = aw_take;
                wr_addr = s_axi_awaddr;
            end
            EPS_WS_RESP:
            begin
                wr_fire = 1'b0;
            end
            default:
            begin
                wr_fire = 1'b0;
            end
        endcase
    end

    // Address compare is zero-extended so narrow buses still decode cleanly
    assign wr_hit = eps_addr_hit(32'(wr_addr));
    assign reg_wr_en = wr_fire && wr_hit;

    // Write channel sequencing: address and data may come in either order
    always_comb
    begin
        ws_nxt = ws_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bresp_nxt = bresp_r;
        case (ws_r)
            EPS_WS_IDLE:
            begin
                if (wr_fire)
                begin
                    ws_nxt = EPS_WS_RESP;
                    bresp_nxt = wr_hit ? EPS_RESP_OKAY : EPS_RESP_SLVERR;
                end
                else if (aw_take)
                begin
                    ws_nxt = EPS_WS_HAVE_ADDR;
                    awaddr_nxt = s_axi_awaddr;
                end
                else if (w_take)
                begin
                    ws_nxt = EPS_WS_HAVE_DATA;
                    wdata_nxt = s_axi_wdata;
                    wstrb_nxt = s_axi_wstrb;
                end
            end
            EPS_WS_HAVE_ADDR, EPS_WS_HAVE_DATA:
            begin
                if (wr_fire)
                begin
                    ws_nxt = EPS_WS_RESP;
                    bresp_nxt = wr_hit ? EPS_RESP_OKAY : EPS_RESP_SLVERR;
                end
            end
            EPS_WS_RESP:
            begin
                // Holding both readies low here keeps one write in flight
                if (s_axi_bready)
                begin
                    ws_nxt = EPS_WS_IDLE;
                    bresp_nxt = EPS_RESP_OKAY;
                end
            end
            default:
            begin
                ws_nxt = EPS_WS_IDLE;
            end
        endcase
    end

    // Write path registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ws_r <= EPS_WS_IDLE;
            awaddr_r <= '0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bresp_r <= EPS_RESP_OKAY;
        end
        else if (ce)
        begin
            ws_r <= ws_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bresp_r <= bresp_nxt;
        end
    end

    // Read channel: data is captured at the address edge and held until taken
    always_comb
    begin
        rs_nxt = rs_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        case (rs_r)
            EPS_RS_IDLE:
            begin
                if (ar_take)
                begin
                    rs_nxt = EPS_RS_DATA;
                    if (eps_addr_hit(32'(s_axi_araddr)))
                    begin
                        rdata_nxt = matrix_q & EPS_MATRIX_WMASK;
                        rresp_nxt = EPS_RESP_OKAY;
                    end
                    else
                    begin
                        rdata_nxt = 32'h0000_0000;
                        rresp_nxt = EPS_RESP_SLVERR;
                    end
                end
            end
            EPS_RS_DATA:
            begin
                if (s_axi_rready)
                begin
                    rs_nxt = EPS_RS_IDLE;
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = EPS_RESP_OKAY;
                end
            end
            default:
            begin
                rs_nxt = EPS_RS_IDLE;
            end
        endcase
    end

    // Read path registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rs_r <= EPS_RS_IDLE;
            rdata_r <= 32'h0000_0000;
            rresp_r <= EPS_RESP_OKAY;
        end
        else if (ce)
        begin
            rs_r <= rs_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // Response outputs come straight from flops
    assign s_axi_bvalid = (ws_r == EPS_WS_RESP);
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = (rs_r == EPS_RS_DATA);
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // Register storage
    eps_reg_word u_word
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .wr_en(reg_wr_en),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .q(matrix_q)
    );

    // Switch line mapping
    eps_switch_map u_map
    (
        .word(matrix_q),
        .sw(switches)
    );
endmodule

//--- sim/eps_switch_ctrl_chk.sv
// Assertion checker for the positive-node switch control block
`timescale 1ns/10ps
module eps_switch_ctrl_chk
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write data and response
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    // Read data
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    // Switch lines
    input wire eps_pkg::eps_switch_s switches
);
    import eps_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Last accepted data beat; the beat may land before the address
    logic [31:0] wd_r;
    logic [3:0] ws_r;
    always_ff @(posedge aclk)
    begin
        if (s_axi_wvalid && s_axi_wready)
        begin
            wd_r <= s_axi_wdata;
            ws_r <= s_axi_wstrb;
        end
    end

    // A good write completes with its byte lane enabled
    sequence s_upd(int lane);
        $rose(s_axi_bvalid) && s_axi_bresp == EPS_RESP_OKAY && ws_r[lane];
    endsequence

    property p_short_load;
        s_upd(1) |-> {switches.load_path_switch_b, switches.output_to_positive_short_switch}
            == wd_r[14:13];
    endproperty
    property p_counter;
        s_upd(1) |-> switches.counter_electrode_switch == wd_r[10];
    endproperty
    property p_fe_three;
        s_upd(1) |-> switches.front_end_three_switch == wd_r[8];
    endproperty
    property p_drive_sense;
        s_upd(0) |-> {switches.drive_electrode_switch, switches.sense_electrode_switch} == wd_r[7:6];
    endproperty
    property p_fe_ref;
        s_upd(0) |-> {switches.front_end_two_switch, switches.reference_electrode_switch}
            == wd_r[5:4];
    endproperty
    property p_ain;
        s_upd(0) |-> {switches.analog_input_three_switch, switches.analog_input_two_switch}
            == wd_r[3:2];
    endproperty
    property p_rd_zero;
        s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h0_0000;
    endproperty
    // A reset may also clear the lines, so the edge after reset is excused
    property p_change;
        $changed(switches) |-> $rose(s_axi_bvalid) || !$past(aresetn);
    endproperty

    a_short_load: assert property (p_short_load)
        else $error("short or load switch does not follow its bit");
    a_counter: assert property (p_counter)
        else $error("counter switch does not follow its bit");
    a_fe_three: assert property (p_fe_three)
        else $error("front end three switch does not follow its bit");
    a_drive_sense: assert property (p_drive_sense)
        else $error("drive or sense switch does not follow its bit");
    a_fe_ref: assert property (p_fe_ref)
        else $error("front end two or reference switch does not follow its bit");
    a_ain: assert property (p_ain)
        else $error("analog input switch does not follow its bit");
    a_rd_zero: assert property (p_rd_zero)
        else $error("upper read bits not zero");
    a_change: assert property (p_change)
        else $error("switch lines moved without a completed write");
endmodule

bind eps_switch_ctrl eps_switch_ctrl_chk u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .switches(switches));

//--- sim/testbench.sv
// Self-checking bench for the positive-node switch control block
`timescale 1ns/10ps
module testbench;
    import eps_pkg::*;
    localparam logic [15:0] ADDR = 16'h2158;
    localparam logic [15:0] HOLE = 16'h2160;
    logic aclk = 0, aresetn = 0, ce = 1;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [15:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 0;
    logic [1:0] bresp, rresp;
    eps_switch_s sw;
    int err_count = 0, samples_checked = 0, cyc = 0;

    eps_switch_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .switches(sw));

    // 25 MHz clock
    always #20 aclk = ~aclk;

    task automatic report_and_stop();
        if (err_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Cuts a hang short; the whole run needs well under this
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    // Address and data offered together, each released once taken
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        logic ga;
        logic gd;
        logic [1:0] b;
        ga = 0;
        gd = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        // Outputs are looked at mid-cycle, where they stand settled for the next edge
        do
        begin
            @(negedge aclk);
            ga = ga | awready;
            gd = gd | wready;
            @(posedge aclk);
            if (ga)
                awvalid <= 0;
            if (gd)
                wvalid <= 0;
        end while (!(ga && gd));
        do
            @(negedge aclk);
        while (bvalid !== 1'b1);
        b = bresp;
        @(posedge aclk);
        bready <= 0;
        chk("bresp", {30'h0, er}, {30'h0, b});
    endtask

    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do
            @(negedge aclk);
        while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 0;
        do
            @(negedge aclk);
        while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        @(posedge aclk);
        rready <= 0;
    endtask

    // Switch lines expected from a stored word, high means closed
    function automatic eps_switch_s exp_sw(input logic [31:0] w);
        return {w[14], w[13], w[10], w[8], w[7], w[6], w[5], w[4], w[3], w[2]};
    endfunction

    task automatic check_state(input logic [31:0] m);
        logic [31:0] d;
        logic [1:0] r;
        rd(ADDR, d, r);
        chk("rresp", 32'h0000_0000, {30'h0, r});
        chk("rdata", m, d);
        chk("switches", {22'h0, exp_sw(m)}, {22'h0, sw});
    endtask

    // Walking one over every bit, reserved and read-only ones included
    task automatic t_bits();
        for (int b = 0; b < 32; b++)
        begin
            wr(ADDR, 32'h0000_0001 << b, 4'hf, EPS_RESP_OKAY);
            check_state((32'h0000_0001 << b) & 32'h0000_7ffc);
        end
    endtask

    // Byte lanes not enabled keep their bits
    task automatic t_strobe();
        wr(ADDR, 32'hffff_ffff, 4'hf, EPS_RESP_OKAY);
        check_state(32'h0000_7ffc);
        wr(ADDR, 32'h0000_0000, 4'h2, EPS_RESP_OKAY);
        check_state(32'h0000_00fc);
        wr(ADDR, 32'h0000_0000, 4'h1, EPS_RESP_OKAY);
        check_state(32'h0000_0000);
    endtask

    // Unmapped accesses are refused and leave the switches alone
    task automatic t_hole();
        logic [31:0] d;
        logic [1:0] r;
        wr(ADDR, 32'h0000_2404, 4'hf, EPS_RESP_OKAY);
        wr(HOLE, 32'hffff_ffff, 4'hf, EPS_RESP_SLVERR);
        rd(HOLE, d, r);
        chk("hole rresp", {30'h0, EPS_RESP_SLVERR}, {30'h0, r});
        chk("hole rdata", 32'h0000_0000, d);
        check_state(32'h0000_2404);
    endtask

    // Reset in mid-run opens every switch
    task automatic t_midreset();
        wr(ADDR, 32'h0000_7ffc, 4'hf, EPS_RESP_OKAY);
        @(posedge aclk);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        check_state(32'h0000_0000);
    endtask

    // Clock enable low stalls a pending write and holds the switches
    task automatic t_freeze();
        wr(ADDR, 32'h0000_0010, 4'hf, EPS_RESP_OKAY);
        @(posedge aclk);
        ce <= 0;
        awaddr <= ADDR;
        wdata <= 32'h0000_0020;
        wstrb <= 4'hf;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        repeat (3)
        begin
            @(negedge aclk);
            chk("frozen awready", 32'h0000_0000, {31'h0, awready});
            chk("frozen wready", 32'h0000_0000, {31'h0, wready});
            chk("frozen switches", {22'h0, exp_sw(32'h0000_0010)}, {22'h0, sw});
        end
        @(posedge aclk);
        ce <= 1;
        @(negedge aclk);
        chk("awready", 32'h0000_0001, {31'h0, awready});
        chk("wready", 32'h0000_0001, {31'h0, wready});
        @(posedge aclk);
        awvalid <= 0;
        wvalid <= 0;
        do
            @(negedge aclk);
        while (bvalid !== 1'b1);
        chk("freeze bresp", {30'h0, EPS_RESP_OKAY}, {30'h0, bresp});
        @(posedge aclk);
        bready <= 0;
        check_state(32'h0000_0020);
    endtask

    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        check_state(32'h0000_0000);
        t_bits();
        t_strobe();
        t_hole();
        t_midreset();
        t_freeze();
        report_and_stop();
    end
endmodule
